// ### rtl/fqbpi_pkg.sv
`default_nettype none

package fqbpi_pkg;

  // Bus geometry
  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned ADDR_LSB = 2;

  typedef logic [IDX_W-1:0] fqbpi_idx_t;

  // Query table indices; byte address is four times the index
  localparam fqbpi_idx_t IDX_PAGE_CAP = 10'h127;
  localparam fqbpi_idx_t IDX_BURST_COUNT = 10'h128;
  localparam fqbpi_idx_t IDX_BURST_ONE = 10'h129;
  localparam fqbpi_idx_t IDX_BURST_TWO = 10'h12a;
  localparam fqbpi_idx_t IDX_BURST_THREE = 10'h12b;
  localparam fqbpi_idx_t IDX_REGION_COUNT = 10'h12c;
  localparam fqbpi_idx_t IDX_REGION_SIZE_LO = 10'h12d;
  localparam fqbpi_idx_t IDX_REGION_SIZE_HI = 10'h12e;
  localparam fqbpi_idx_t IDX_REGION_EXTRA = 10'h12f;
  localparam fqbpi_idx_t IDX_IDENT_PARTS = 10'h130;
  localparam fqbpi_idx_t IDX_LOCAL_CONC = 10'h131;
  localparam fqbpi_idx_t IDX_CONC_PROGRAM = 10'h132;
  localparam fqbpi_idx_t IDX_CONC_ERASE = 10'h133;

  // Block control and status words
  localparam fqbpi_idx_t IDX_CTRL = 10'h140;
  localparam fqbpi_idx_t IDX_STATUS = 10'h141;
  localparam int unsigned CTRL_MUX_BIT = 0;
  localparam logic CTRL_MUX_RESET = 1'b0;
  localparam int unsigned STATUS_MUX_BIT = 0;
  localparam int unsigned STATUS_LAST_LSB = 16;

  // Fixed table contents
  localparam logic [7:0] PAGE_EXP_NONMUX = 8'h05;
  localparam logic [7:0] PAGE_EXP_MUX = 8'h00;
  localparam logic [7:0] BURST_FIELD_COUNT = 8'h03;
  localparam logic [7:0] BURST_N_ONE = 8'h02;
  localparam logic [7:0] BURST_N_TWO = 8'h03;
  localparam logic [7:0] BURST_N_CONT = 8'h07;
  localparam logic [7:0] BURST_N_MASK = 8'h07;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_DATA, RD_RESP} fqbpi_rd_state_t;
  typedef enum logic [1:0] {WR_COLLECT, WR_COMMIT, WR_RESP} fqbpi_wr_state_t;

  function automatic fqbpi_idx_t fqbpi_idx_of(input logic [AXI_ADDR_W-1:0] addr);
    return addr[AXI_ADDR_W-1:ADDR_LSB];
  endfunction : fqbpi_idx_of

  function automatic logic fqbpi_is_query(input fqbpi_idx_t idx);
    return (idx >= IDX_PAGE_CAP) && (idx <= IDX_CONC_ERASE);
  endfunction : fqbpi_is_query

  // Only the 3-bit burst code is live; the upper five bits read as zero
  function automatic logic [7:0] fqbpi_burst_field(input logic [7:0] n);
    return n & BURST_N_MASK;
  endfunction : fqbpi_burst_field

endpackage : fqbpi_pkg

`default_nettype wire

// ### rtl/fqbpi_query_rom.sv
`default_nettype none

module fqbpi_query_rom #(
  parameter logic [7:0] REGION_COUNT = 8'h01,
  parameter logic [15:0] REGION_INFO_SIZE = 16'h0011,
  parameter logic [7:0] REGION_EXTRA = 8'h00,
  parameter logic [7:0] IDENT_PARTS = 8'h08,
  parameter logic [7:0] LOCAL_CONC = 8'h11,
  parameter logic [7:0] CONC_PROGRAM = 8'h00,
  parameter logic [7:0] CONC_ERASE = 8'h00
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Lookup
  input wire fqbpi_pkg::fqbpi_idx_t idx,
  input wire logic mux_variant,
  // Registered answer
  output logic [7:0] data_q
);
  import fqbpi_pkg::*;

  typedef struct packed {
    logic [7:0] data;
  } fqbpi_rom_state_t;

  fqbpi_rom_state_t s_q;
  fqbpi_rom_state_t s_d;

  always_comb begin
    s_d = s_q;
    unique case (idx)
      // Page size is 2**n bytes; zero means no page buffer
      IDX_PAGE_CAP: s_d.data = mux_variant ? PAGE_EXP_MUX : PAGE_EXP_NONMUX;
      IDX_BURST_COUNT: s_d.data = BURST_FIELD_COUNT;
      IDX_BURST_ONE: s_d.data = fqbpi_burst_field(BURST_N_ONE);
      IDX_BURST_TWO: s_d.data = fqbpi_burst_field(BURST_N_TWO);
      IDX_BURST_THREE: s_d.data = fqbpi_burst_field(BURST_N_CONT);
      IDX_REGION_COUNT: s_d.data = REGION_COUNT;
      IDX_REGION_SIZE_LO: s_d.data = REGION_INFO_SIZE[7:0];
      IDX_REGION_SIZE_HI: s_d.data = REGION_INFO_SIZE[15:8];
      IDX_REGION_EXTRA: s_d.data = REGION_EXTRA;
      IDX_IDENT_PARTS: s_d.data = IDENT_PARTS;
      IDX_LOCAL_CONC: s_d.data = LOCAL_CONC;
      IDX_CONC_PROGRAM: s_d.data = CONC_PROGRAM;
      IDX_CONC_ERASE: s_d.data = CONC_ERASE;
      default: s_d.data = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_q = s_q.data;

endmodule : fqbpi_query_rom

`default_nettype wire

// ### rtl/fqbpi_query_table.sv
`default_nettype none

module fqbpi_query_table #(
  parameter logic [7:0] REGION_COUNT = 8'h01,
  parameter logic [15:0] REGION_INFO_SIZE = 16'h0011,
  parameter logic [7:0] REGION_EXTRA = 8'h00,
  parameter logic [7:0] IDENT_PARTS = 8'h08,
  parameter logic [7:0] LOCAL_CONC = 8'h11,
  parameter logic [7:0] CONC_PROGRAM = 8'h00,
  parameter logic [7:0] CONC_ERASE = 8'h00
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [fqbpi_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [fqbpi_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [fqbpi_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [fqbpi_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import fqbpi_pkg::*;

  typedef struct packed {
    // Write side
    fqbpi_wr_state_t wr_state;
    logic aw_ready;
    logic w_ready;
    logic aw_held;
    logic w_held;
    fqbpi_idx_t wr_idx;
    logic [7:0] wr_byte;
    logic wr_lane0;
    logic b_valid;
    logic [1:0] b_resp;
    // Read side
    fqbpi_rd_state_t rd_state;
    logic ar_ready;
    fqbpi_idx_t rd_idx;
    logic r_valid;
    logic [1:0] r_resp;
    logic [AXI_DATA_W-1:0] r_data;
    // Block state
    logic mux_variant;
    fqbpi_idx_t last_query;
  } fqbpi_state_t;

  fqbpi_state_t s_q;
  fqbpi_state_t s_d;

  logic [7:0] rom_data;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic b_fire;
  logic r_fire;
  logic wr_ok;
  logic rd_query;
  logic rd_ctrl;
  logic rd_status;
  logic [AXI_DATA_W-1:0] ctrl_word;
  logic [AXI_DATA_W-1:0] status_word;

  // The table sits in its own lookup so read data always leave a flop
  fqbpi_query_rom #(
    .REGION_COUNT(REGION_COUNT),
    .REGION_INFO_SIZE(REGION_INFO_SIZE),
    .REGION_EXTRA(REGION_EXTRA),
    .IDENT_PARTS(IDENT_PARTS),
    .LOCAL_CONC(LOCAL_CONC),
    .CONC_PROGRAM(CONC_PROGRAM),
    .CONC_ERASE(CONC_ERASE)
  ) u_rom (
    .aclk(aclk),
    .aresetn(aresetn),
    .idx(s_q.rd_idx),
    .mux_variant(s_q.mux_variant),
    .data_q(rom_data)
  );

  assign aw_fire = s_axi_awvalid && s_q.aw_ready;
  assign w_fire = s_axi_wvalid && s_q.w_ready;
  assign ar_fire = s_axi_arvalid && s_q.ar_ready;
  assign b_fire = s_q.b_valid && s_axi_bready;
  assign r_fire = s_q.r_valid && s_axi_rready;

  // Only the control word takes writes; query entries are fixed
  assign wr_ok = (s_q.wr_idx == IDX_CTRL);

  assign rd_query = fqbpi_is_query(s_q.rd_idx);
  assign rd_ctrl = (s_q.rd_idx == IDX_CTRL);
  assign rd_status = (s_q.rd_idx == IDX_STATUS);

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_MUX_BIT] = s_q.mux_variant;
  end

  always_comb begin
    status_word = '0;
    status_word[STATUS_MUX_BIT] = s_q.mux_variant;
    status_word[STATUS_LAST_LSB +: IDX_W] = s_q.last_query;
  end

  always_comb begin
    s_d = s_q;

    // Write channel: address and data may arrive in either order
    unique case (s_q.wr_state)
      WR_COLLECT: begin
        if (aw_fire) begin
          s_d.aw_ready = 1'b0;
          s_d.aw_held = 1'b1;
          s_d.wr_idx = fqbpi_idx_of(s_axi_awaddr);
        end
        if (w_fire) begin
          s_d.w_ready = 1'b0;
          s_d.w_held = 1'b1;
          s_d.wr_byte = s_axi_wdata[7:0];
          s_d.wr_lane0 = s_axi_wstrb[0];
        end
        if (s_d.aw_held && s_d.w_held) begin
          s_d.wr_state = WR_COMMIT;
        end
      end
      WR_COMMIT: begin
        if (wr_ok && s_q.wr_lane0) begin
          // Variant choice steers the page byte served from the table
          s_d.mux_variant = s_q.wr_byte[CTRL_MUX_BIT];
        end
        s_d.b_resp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        s_d.b_valid = 1'b1;
        s_d.aw_held = 1'b0;
        s_d.w_held = 1'b0;
        s_d.wr_state = WR_RESP;
      end
      WR_RESP: begin
        if (b_fire) begin
          s_d.b_valid = 1'b0;
          s_d.aw_ready = 1'b1;
          s_d.w_ready = 1'b1;
          s_d.wr_state = WR_COLLECT;
        end
      end
    endcase

    // Read channel: one cycle to index the table, one to form the word
    unique case (s_q.rd_state)
      RD_IDLE: begin
        if (ar_fire) begin
          s_d.ar_ready = 1'b0;
          s_d.rd_idx = fqbpi_idx_of(s_axi_araddr);
          s_d.rd_state = RD_FETCH;
        end
      end
      RD_FETCH: begin
        s_d.rd_state = RD_DATA;
      end
      RD_DATA: begin
        s_d.r_data = '0;
        s_d.r_resp = RESP_OKAY;
        if (rd_query) begin
          // Byte in the low lane, everything above reads zero
          s_d.r_data[7:0] = rom_data;
          s_d.last_query = s_q.rd_idx;
        end else if (rd_ctrl) begin
          s_d.r_data = ctrl_word;
        end else if (rd_status) begin
          s_d.r_data = status_word;
        end else begin
          s_d.r_resp = RESP_SLVERR;
        end
        s_d.r_valid = 1'b1;
        s_d.rd_state = RD_RESP;
      end
      RD_RESP: begin
        if (r_fire) begin
          s_d.r_valid = 1'b0;
          s_d.ar_ready = 1'b1;
          s_d.rd_state = RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.wr_state <= WR_COLLECT;
      s_q.rd_state <= RD_IDLE;
      s_q.aw_ready <= 1'b1;
      s_q.w_ready <= 1'b1;
      s_q.ar_ready <= 1'b1;
      s_q.b_resp <= RESP_OKAY;
      s_q.r_resp <= RESP_OKAY;
      s_q.mux_variant <= CTRL_MUX_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Every bus output is a flop of the state record
  assign s_axi_awready = s_q.aw_ready;
  assign s_axi_wready = s_q.w_ready;
  assign s_axi_bvalid = s_q.b_valid;
  assign s_axi_bresp = s_q.b_resp;
  assign s_axi_arready = s_q.ar_ready;
  assign s_axi_rvalid = s_q.r_valid;
  assign s_axi_rresp = s_q.r_resp;
  assign s_axi_rdata = s_q.r_data;

endmodule : fqbpi_query_table

`default_nettype wire

// ### verification/fqbpi_checker_props.sv
`default_nettype none
module fqbpi_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read channels
  input wire logic [fqbpi_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [fqbpi_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  import fqbpi_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  fqbpi_idx_t idx_q;
  logic v;
  logic q;
  logic [7:0] lo;
  // Only one read is in flight, so this names the entry of the pending answer
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready) idx_q <= s_axi_araddr[11:2];
  assign v = s_axi_rvalid;
  assign lo = s_axi_rdata[7:0];
  assign q = idx_q >= IDX_PAGE_CAP && idx_q <= IDX_CONC_ERASE;
  // Lookup and word forming take one edge each, so valid is first seen on the third edge
  property p_lat; s_axi_arvalid && s_axi_arready |=> !v ##1 !v ##1 v; endproperty
  a_lat: assert property (p_lat) else $error("read answer late");
  property p_hold; v && !s_axi_rready |=> v && $stable(s_axi_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_lane; v && q |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == RESP_OKAY; endproperty
  a_lane: assert property (p_lane) else $error("upper lane not zero");
  property p_page; v && idx_q == IDX_PAGE_CAP |-> lo inside {8'h05, 8'h00}; endproperty
  a_page: assert property (p_page) else $error("page byte wrong");
  property p_cnt; v && idx_q == IDX_BURST_COUNT |-> lo == 8'h03; endproperty
  a_cnt: assert property (p_cnt) else $error("field count wrong");
  property p_b1; v && idx_q == IDX_BURST_ONE |-> lo == 8'h02; endproperty
  a_b1: assert property (p_b1) else $error("burst one wrong");
  property p_b2; v && idx_q == IDX_BURST_TWO |-> lo == 8'h03; endproperty
  a_b2: assert property (p_b2) else $error("burst two wrong");
  property p_b3; v && idx_q == IDX_BURST_THREE |-> lo == 8'h07; endproperty
  a_b3: assert property (p_b3) else $error("burst three wrong");
  property p_rsv; v && idx_q >= IDX_BURST_ONE && idx_q <= IDX_BURST_THREE |-> lo[7:3] == 5'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  c_fast: cover property (v && s_axi_rready && q);
  c_slow: cover property (v && !s_axi_rready);
  c_err: cover property (v && s_axi_rresp == RESP_SLVERR);
endmodule : fqbpi_checker
bind fqbpi_query_table fqbpi_checker u_chk (.*);
`default_nettype wire

// ### verification/fqbpi_host.sv
`default_nettype none
module fqbpi_host (
  // Clock
  input wire logic aclk,
  // Requests toward the table
  output logic [11:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic [2:0] s_axi_awprot, s_axi_arprot,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  // Answers from the table
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] burst_len = 3'h0;
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot,
    s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  // Burst setting taken from the low three bits of a burst field
  task automatic take_burst(input logic [31:0] f);
    burst_len = f[2:0];
  endtask : take_burst
  // Released payload is inverted so a late sample never sees the old value
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [2:0] p, input int dly, output logic [1:0] r);
    logic pa;
    logic pw;
    pa = '1;
    pw = '1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awprot <= p;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        pa = '0;
        s_axi_awvalid <= '0;
        s_axi_awaddr <= ~a;
      end
      if (pw && s_axi_wready) begin
        pw = '0;
        s_axi_wvalid <= '0;
        s_axi_wdata <= ~d;
      end
    end
    repeat (dly) @(posedge aclk);
    s_axi_bready <= '1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= '0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [2:0] p, input int dly,
    output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arprot <= p;
    s_axi_arvalid <= '1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= '0;
    s_axi_araddr <= ~a;
    repeat (dly) @(posedge aclk);
    s_axi_rready <= '1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= '0;
  endtask : rd
endmodule : fqbpi_host
`default_nettype wire

// ### verification/fqbpi_query_table_bench.sv
`default_nettype none
module fqbpi_query_table_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fqbpi_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int n_compared = 0;
  int variant = 0;
  int last = 0;
  logic [31:0] seed = 32'd21769;
  // Region entries get distinct values so a swapped entry shows up
  int tbl [13] = '{'h05, 'h03, 'h02, 'h03, 'h07, 'h03, 'h11, 'h0c, 'h5a, 'h08, 'h21, 'h14, 'h41};
  fqbpi_query_table #(.REGION_COUNT(8'h03), .REGION_INFO_SIZE(16'h0c11), .REGION_EXTRA(8'h5a),
    .IDENT_PARTS(8'h08), .LOCAL_CONC(8'h21), .CONC_PROGRAM(8'h14), .CONC_ERASE(8'h41)) uut (.*);
  fqbpi_host host (.*);
  always #50 aclk = ~aclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic model(input int i, output logic [31:0] d, output logic [1:0] r);
    d = 0;
    r = RESP_OKAY;
    if (i >= 'h127 && i <= 'h133) begin
      d = (i == 'h127 && variant) ? 0 : tbl[i - 'h127];
      last = i;
    end else if (i == 'h140) d = variant;
    else if (i == 'h141) d = (last << 16) | variant;
    else r = RESP_SLVERR;
  endtask : model
  task automatic rdc(input int i);
    logic [31:0] d, e;
    logic [1:0] r, er;
    // A wait of up to four edges lets the answer stand before ready comes
    host.rd(12'(i * 4), 3'(xs()), xs() % 5, d, r);
    model(i, e, er);
    chk(d, e);
    chk(32'(r), 32'(er));
    if (i >= 'h129 && i <= 'h12b) begin
      host.take_burst(d);
      chk(32'(host.burst_len), e & 7);
    end
  endtask : rdc
  task automatic wrc(input int i, input logic [31:0] v, input logic [3:0] s);
    logic [1:0] r;
    host.wr(12'(i * 4), v, s, 3'(xs()), xs() % 5, r);
    if (i == 'h140 && s[0]) variant = v[0];
    chk(32'(r), i == 'h140 ? 32'(RESP_OKAY) : 32'(RESP_SLVERR));
  endtask : wrc
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 'h127; i <= 'h133; i++) rdc(i);
    rdc('h141);
    rdc(0);
    // Strobe off must leave the variant alone
    wrc('h140, 1, 4'h0);
    rdc('h127);
    wrc('h140, 1, 4'hf);
    rdc('h127);
    wrc('h12b, 0, 4'hf);
    rdc('h12b);
    repeat (60) begin
      rdc('h127 + xs() % 13);
      if (xs() % 4 == 0) wrc('h140, xs(), 4'hf);
    end
    rdc('h141);
    // Reset in mid-run must restore the variant and clear the recorded index
    aresetn <= 1'b0;
    variant = 0;
    last = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc('h141);
    rdc('h127);
    results();
  end
  initial begin
    #300us;
    num_errors++;
    results();
  end
endmodule : fqbpi_query_table_bench
`default_nettype wire
